/* File: irq_pkg.sv */
// Constants, types and decode helpers for the interrupt request and priority block
// What this block does
// - A presented third-bank source sets its bit in the third request register.
// - With global enable set, latched requests are forwarded to the core as vectors.
// - With global enable clear, no vector is raised; the core polls the register.
// - Multi-channel timer request sits at bit 6 of the third request register.
// - Second serial port receive at bit 5, transmit at bit 4.
// - Port C pins 0 to 3 sit at bits 0 to 3, same index.
// - First bank: high/low enable pair gives off, level 1, 2 or 3.
// - Second bank uses the same pair encoding at each bit position.
// - First-bank high enables: timers 2,1,0, serial 0 rx, tx, two-wire, sync serial, converter.
// - First-bank low enables use the same source order as the high enables.
// - Second-bank high enables: pin7/detect, pin6/cmp0, pin5/cmp1, shared pins 4-1, pin 0.
// - Second-bank low enables share the per-bit assignment of the high enables.
// - A source-select setting picks port A or port D for shared positions.
// - Acknowledging a vector clears that source's request bit automatically.
// - A software-written one raises a vectored request; only a hardware set raises the new-request event.
package irq_pkg;

  localparam int DATA_W = 8;
  localparam int REG_IDX_W = 12;
  localparam int NUM_SOURCES = 24;
  localparam int SRC_W = 5;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_BANK0_PRIO_HIGH = 12'hFC1;
  localparam logic [11:0] IDX_BANK0_PRIO_LOW = 12'hFC2;
  localparam logic [11:0] IDX_BANK1_PRIO_HIGH = 12'hFC4;
  localparam logic [11:0] IDX_BANK1_PRIO_LOW = 12'hFC5;
  localparam logic [11:0] IDX_BANK2_REQUEST = 12'hFC6;
  localparam logic [11:0] IDX_SHARED_SELECT = 12'hFCE;
  localparam logic [11:0] IDX_GLOBAL_CTRL = 12'hFD0;
  localparam logic [11:0] IDX_EVENT_STATUS = 12'hFD1;
  localparam logic [11:0] IDX_EVENT_MASK = 12'hFD2;

  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Third request register layout
  localparam int BIT_RESERVED = 7;
  localparam int BIT_MCT = 6;
  localparam int BIT_SERIAL1_RX = 5;
  localparam int BIT_SERIAL1_TX = 4;
  localparam int BIT_PORTC_LSB = 0;
  localparam logic [7:0] BANK2_WRITABLE = 8'h7F;

  // Shared select layout: bit 0 is reserved, pin 0 is always port A
  localparam logic [7:0] SHARED_WRITABLE = 8'hFE;

  // Own control and event bits
  localparam int CTRL_GLOBAL_EN = 0;
  localparam int EV_NEW_REQUEST = 0;
  localparam int EV_VECTOR_ACK = 1;
  localparam logic [7:0] EV_WRITABLE = 8'h03;

  // Quiet cycles after an acknowledge so external latches can clear
  localparam logic [1:0] ACK_HOLDOFF_CYCLES = 2'd2;

  typedef enum logic [1:0] {
    LVL_OFF = 2'b00,
    LVL_LOW = 2'b01,
    LVL_NOMINAL = 2'b10,
    LVL_HIGH = 2'b11
  } prio_level_t;

  typedef enum logic [2:0] {
    VS_IDLE = 3'b001,
    VS_PRESENT = 3'b010,
    VS_HOLDOFF = 3'b100
  } vec_state_t;

  function automatic prio_level_t prio_level(input logic high, input logic low);
    return prio_level_t'({high, low});
  endfunction

endpackage

/* File: irq_priority_pick.sv */
// Picks the highest enabled pending source; ties go to the lowest index
`timescale 1ns/1ps
`default_nettype none
module irq_priority_pick #(
  parameter int N = 24,
  parameter int IDX_W = 5
) (
  // Candidates
  input wire logic [N-1:0] pending,
  input wire logic [2*N-1:0] levels,
  // Winner
  output logic found,
  output logic [IDX_W-1:0] win_idx,
  output logic [1:0] win_level
);
  import irq_pkg::*;

  if (N < 2 || (1 << IDX_W) < N) begin : g_bad_size
    $error("irq_priority_pick: N and IDX_W do not fit");
  end

  always_comb begin
    found = 1'b0;
    win_idx = '0;
    win_level = LVL_OFF;
    for (int i = 0; i < N; i++) begin
      // Disabled sources never win, strict compare keeps lower index on ties
      if (pending[i] && levels[2*i +: 2] != LVL_OFF && levels[2*i +: 2] > win_level) begin
        found = 1'b1;
        win_idx = IDX_W'(i);
        win_level = levels[2*i +: 2];
      end
    end
  end

endmodule
`default_nettype wire

/* File: irq_request_priority_enable.sv */
// Third request bank, first and second bank priority enables, vector presentation
`timescale 1ns/1ps
`default_nettype none
module irq_request_priority_enable #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Third-bank sources
  input wire logic multichannel_timer_request,
  input wire logic serial1_receive_request,
  input wire logic serial1_transmit_request,
  input wire logic [3:0] portc_pin_request,
  // Third-bank enables held outside this block
  input wire logic [irq_pkg::DATA_W-1:0] bank2_enable_high,
  input wire logic [irq_pkg::DATA_W-1:0] bank2_enable_low,
  // First and second request latches held outside this block
  input wire logic [irq_pkg::DATA_W-1:0] bank0_request_latch,
  input wire logic [irq_pkg::DATA_W-1:0] bank1_request_latch,
  output logic [irq_pkg::DATA_W-1:0] bank0_ack_clear,
  output logic [irq_pkg::DATA_W-1:0] bank1_ack_clear,
  // Second-bank shared sources
  input wire logic [7:0] porta_pin_request,
  input wire logic [4:1] portd_pin_request,
  input wire logic low_voltage_detect,
  input wire logic comparator0_request,
  input wire logic comparator1_request,
  output logic [irq_pkg::DATA_W-1:0] bank1_source_request,
  // Vectored request to the core
  output logic vec_req,
  output logic [irq_pkg::SRC_W-1:0] vec_source,
  output logic [1:0] vec_level,
  input wire logic vec_ack,
  // Level interrupt
  output logic irq
);
  import irq_pkg::*;

  if (ADDR_W < REG_IDX_W + 2 || ADDR_W > 32) begin : g_bad_addr
    $error("irq_request_priority_enable: ADDR_W must be 14 to 32");
  end

  logic [DATA_W-1:0] bank0_prio_high_q;
  logic [DATA_W-1:0] bank0_prio_low_q;
  logic [DATA_W-1:0] bank1_prio_high_q;
  logic [DATA_W-1:0] bank1_prio_low_q;
  logic [DATA_W-1:0] bank2_request_latch_q;
  logic [DATA_W-1:0] bank2_request_latch_d;
  logic [DATA_W-1:0] shared_source_select_q;
  logic [DATA_W-1:0] global_ctrl_q;
  logic [DATA_W-1:0] event_status_q;
  logic [DATA_W-1:0] event_mask_q;
  logic [DATA_W-1:0] bank2_hw_set;
  logic [DATA_W-1:0] bank2_ack_clr;
  logic [DATA_W-1:0] bank1_source_d;
  logic [4:1] shared_pick;
  logic ack_q;
  logic [31:0] dat_q;
  logic bus_req;
  logic wr_now;
  logic [REG_IDX_W-1:0] reg_idx;
  logic [DATA_W-1:0] wr_byte;
  logic [DATA_W-1:0] rd_byte;
  logic global_en;
  vec_state_t state_q;
  vec_state_t state_d;
  logic [SRC_W-1:0] vec_source_q;
  logic [1:0] vec_level_q;
  logic [1:0] holdoff_q;
  logic [NUM_SOURCES-1:0] all_pending;
  logic [2*NUM_SOURCES-1:0] all_levels;
  logic pick_found;
  logic [SRC_W-1:0] pick_idx;
  logic [1:0] pick_level;
  logic ack_taken;
  logic new_request_event;

  // Bus decode
  assign bus_req = cyc_i && stb_i;
  // Write lands at the edge where the master sees ack
  assign wr_now = bus_req && we_i && ack_q && sel_i[0];
  assign reg_idx = adr_i[REG_IDX_W+1:2];
  assign wr_byte = dat_i[DATA_W-1:0];
  assign global_en = global_ctrl_q[CTRL_GLOBAL_EN];

  function automatic logic hits(input logic [REG_IDX_W-1:0] idx,
                                input logic [ADDR_W-1:0] adr);
    logic upper_zero;
    upper_zero = 1'b1;
    for (int i = REG_IDX_W + 2; i < ADDR_W; i++) begin
      if (adr[i]) begin
        upper_zero = 1'b0;
      end
    end
    return upper_zero && (adr[REG_IDX_W+1:2] == idx);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end
  assign ack_o = ack_q;

  // Read mux; unmapped indices read zero
  always_comb begin
    rd_byte = RESET_VALUE;
    if (hits(IDX_BANK0_PRIO_HIGH, adr_i)) begin
      rd_byte = bank0_prio_high_q;
    end else if (hits(IDX_BANK0_PRIO_LOW, adr_i)) begin
      rd_byte = bank0_prio_low_q;
    end else if (hits(IDX_BANK1_PRIO_HIGH, adr_i)) begin
      rd_byte = bank1_prio_high_q;
    end else if (hits(IDX_BANK1_PRIO_LOW, adr_i)) begin
      rd_byte = bank1_prio_low_q;
    end else if (hits(IDX_BANK2_REQUEST, adr_i)) begin
      rd_byte = bank2_request_latch_q;
    end else if (hits(IDX_SHARED_SELECT, adr_i)) begin
      rd_byte = shared_source_select_q;
    end else if (hits(IDX_GLOBAL_CTRL, adr_i)) begin
      rd_byte = global_ctrl_q;
    end else if (hits(IDX_EVENT_STATUS, adr_i)) begin
      rd_byte = event_status_q;
    end else if (hits(IDX_EVENT_MASK, adr_i)) begin
      rd_byte = event_mask_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dat_q <= 32'h0000_0000;
    end else if (bus_req && !ack_q && !we_i) begin
      dat_q <= {{(32-DATA_W){1'b0}}, rd_byte};
    end
  end
  assign dat_o = dat_q;

  // First-bank priority enables, bit order shared by high and low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank0_prio_high_q <= RESET_VALUE;
      bank0_prio_low_q <= RESET_VALUE;
    end else if (wr_now) begin
      if (hits(IDX_BANK0_PRIO_HIGH, adr_i)) begin
        bank0_prio_high_q <= wr_byte;
      end
      if (hits(IDX_BANK0_PRIO_LOW, adr_i)) begin
        bank0_prio_low_q <= wr_byte;
      end
    end
  end

  // Second-bank priority enables
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank1_prio_high_q <= RESET_VALUE;
      bank1_prio_low_q <= RESET_VALUE;
    end else if (wr_now) begin
      if (hits(IDX_BANK1_PRIO_HIGH, adr_i)) begin
        bank1_prio_high_q <= wr_byte;
      end
      if (hits(IDX_BANK1_PRIO_LOW, adr_i)) begin
        bank1_prio_low_q <= wr_byte;
      end
    end
  end

  // Shared source select and global enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shared_source_select_q <= RESET_VALUE;
      global_ctrl_q <= RESET_VALUE;
    end else if (wr_now) begin
      if (hits(IDX_SHARED_SELECT, adr_i)) begin
        shared_source_select_q <= wr_byte & SHARED_WRITABLE;
      end
      if (hits(IDX_GLOBAL_CTRL, adr_i)) begin
        global_ctrl_q <= wr_byte & (8'h01 << CTRL_GLOBAL_EN);
      end
    end
  end

  // Second-bank source steering, registered toward the external latch
  always_comb begin
    bank1_source_d = RESET_VALUE;
    bank1_source_d[0] = porta_pin_request[0];
    bank1_source_d[4:1] = shared_pick;
    bank1_source_d[7] = shared_source_select_q[7] ? low_voltage_detect
                                                  : porta_pin_request[7];
    bank1_source_d[6] = shared_source_select_q[6] ? comparator0_request
                                                  : porta_pin_request[6];
    bank1_source_d[5] = shared_source_select_q[5] ? comparator1_request
                                                  : porta_pin_request[5];
  end

  genvar g;
  generate
    for (g = 1; g <= 4; g++) begin : g_shared_pin
      assign shared_pick[g] = shared_source_select_q[g] ? portd_pin_request[g]
                                                        : porta_pin_request[g];
    end
  endgenerate

  // One process drives the whole steered byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank1_source_request <= RESET_VALUE;
    end else begin
      bank1_source_request <= bank1_source_d;
    end
  end

  // Third-bank request latch
  always_comb begin
    bank2_hw_set = RESET_VALUE;
    bank2_hw_set[BIT_MCT] = multichannel_timer_request;
    bank2_hw_set[BIT_SERIAL1_RX] = serial1_receive_request;
    bank2_hw_set[BIT_SERIAL1_TX] = serial1_transmit_request;
    bank2_hw_set[BIT_PORTC_LSB +: 4] = portc_pin_request;
  end

  always_comb begin
    bank2_ack_clr = RESET_VALUE;
    if (ack_taken && vec_source_q >= SRC_W'(2 * DATA_W)) begin
      bank2_ack_clr[vec_source_q[2:0]] = 1'b1;
    end
  end

  // Software write keeps its value, hardware set wins over any clear
  always_comb begin
    bank2_request_latch_d = bank2_request_latch_q & ~bank2_ack_clr;
    if (wr_now && hits(IDX_BANK2_REQUEST, adr_i)) begin
      bank2_request_latch_d = wr_byte;
    end
    bank2_request_latch_d = (bank2_request_latch_d | bank2_hw_set) & BANK2_WRITABLE;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank2_request_latch_q <= RESET_VALUE;
    end else begin
      bank2_request_latch_q <= bank2_request_latch_d;
    end
  end

  // Candidate vectors, index is bank times eight plus bit
  generate
    for (g = 0; g < DATA_W; g++) begin : g_levels
      assign all_levels[2*g +: 2] = prio_level(bank0_prio_high_q[g],
                                               bank0_prio_low_q[g]);
      assign all_levels[2*(g+DATA_W) +: 2] = prio_level(bank1_prio_high_q[g],
                                                        bank1_prio_low_q[g]);
      assign all_levels[2*(g+2*DATA_W) +: 2] = prio_level(bank2_enable_high[g],
                                                          bank2_enable_low[g]);
    end
  endgenerate

  assign all_pending = {bank2_request_latch_q, bank1_request_latch, bank0_request_latch};

  irq_priority_pick #(
    .N(NUM_SOURCES),
    .IDX_W(SRC_W)
  ) u_pick (
    .pending(all_pending),
    .levels(all_levels),
    .found(pick_found),
    .win_idx(pick_idx),
    .win_level(pick_level)
  );

  // Vector presentation
  // An acknowledge counts only while the vector is actually shown
  assign ack_taken = (state_q == VS_PRESENT) && global_en && vec_ack;

  always_comb begin
    state_d = state_q;
    case (state_q)
      VS_IDLE: begin
        if (global_en && pick_found) begin
          state_d = VS_PRESENT;
        end
      end
      VS_PRESENT: begin
        if (ack_taken) begin
          state_d = VS_HOLDOFF;
        end else if (!global_en || !pick_found) begin
          state_d = VS_IDLE;
        end
      end
      VS_HOLDOFF: begin
        if (holdoff_q == 2'd1) begin
          state_d = VS_IDLE;
        end
      end
      default: begin
        state_d = VS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= VS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      holdoff_q <= 2'd0;
    end else if (ack_taken) begin
      holdoff_q <= ACK_HOLDOFF_CYCLES;
    end else if (holdoff_q != 2'd0) begin
      holdoff_q <= holdoff_q - 2'd1;
    end
  end

  // Follows the best candidate each cycle so a higher level preempts
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vec_source_q <= '0;
      vec_level_q <= LVL_OFF;
    end else if (state_d == VS_PRESENT && !ack_taken) begin
      vec_source_q <= pick_idx;
      vec_level_q <= pick_level;
    end
  end

  assign vec_req = (state_q == VS_PRESENT) && global_en;
  assign vec_source = vec_source_q;
  assign vec_level = vec_level_q;

  // One-cycle clear pulses toward the external latches
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bank0_ack_clear <= RESET_VALUE;
      bank1_ack_clear <= RESET_VALUE;
    end else begin
      bank0_ack_clear <= RESET_VALUE;
      bank1_ack_clear <= RESET_VALUE;
      if (ack_taken && vec_source_q < SRC_W'(DATA_W)) begin
        bank0_ack_clear[vec_source_q[2:0]] <= 1'b1;
      end
      if (ack_taken && vec_source_q >= SRC_W'(DATA_W)
          && vec_source_q < SRC_W'(2 * DATA_W)) begin
        bank1_ack_clear[vec_source_q[2:0]] <= 1'b1;
      end
    end
  end

  // Event status, set wins over write-one-to-clear
  assign new_request_event = |(bank2_hw_set & ~bank2_request_latch_q & BANK2_WRITABLE);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      event_status_q <= RESET_VALUE;
      event_mask_q <= RESET_VALUE;
    end else begin
      if (wr_now && hits(IDX_EVENT_STATUS, adr_i)) begin
        event_status_q <= (event_status_q & ~wr_byte)
                        | ({{(DATA_W-1){1'b0}}, new_request_event} << EV_NEW_REQUEST)
                        | ({{(DATA_W-1){1'b0}}, ack_taken} << EV_VECTOR_ACK);
      end else begin
        event_status_q <= event_status_q
                        | ({{(DATA_W-1){1'b0}}, new_request_event} << EV_NEW_REQUEST)
                        | ({{(DATA_W-1){1'b0}}, ack_taken} << EV_VECTOR_ACK);
      end
      if (wr_now && hits(IDX_EVENT_MASK, adr_i)) begin
        event_mask_q <= wr_byte & EV_WRITABLE;
      end
    end
  end

  assign irq = |(event_status_q & event_mask_q);

endmodule
`default_nettype wire

/* File: irq_rpe_chk.sv */
// Port checks for the request and priority block
`timescale 1ns/1ps
`default_nettype none
module irq_rpe_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Vector link
  input wire logic vec_req,
  input wire logic vec_ack,
  input wire logic [irq_pkg::SRC_W-1:0] vec_source,
  input wire logic [1:0] vec_level,
  input wire logic [irq_pkg::DATA_W-1:0] bank0_ack_clear,
  input wire logic [irq_pkg::DATA_W-1:0] bank1_ack_clear,
  // Steering
  input wire logic [7:0] porta_pin_request,
  input wire logic [irq_pkg::DATA_W-1:0] bank1_source_request
);
  logic [4:0] src_q;
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Source seen at the acknowledge edge
  always_ff @(posedge sys_clk) begin
    src_q <= vec_source;
  end
  property p_ack_next;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus access not acked");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_quiet;
    vec_req && vec_ack |=> !vec_req [*2];
  endproperty
  a_ack_quiet: assert property (p_ack_quiet) else $error("vector not withdrawn");
  property p_clr0;
    vec_req && vec_ack |=> bank0_ack_clear == ((src_q < 5'd8) ? (8'h01 << src_q[2:0]) : 8'h00);
  endproperty
  a_clr0: assert property (p_clr0) else $error("bank0 clear wrong");
  property p_clr1;
    vec_req && vec_ack |=>
      bank1_ack_clear == ((src_q[4:3] == 2'b01) ? (8'h01 << src_q[2:0]) : 8'h00);
  endproperty
  a_clr1: assert property (p_clr1) else $error("bank1 clear wrong");
  property p_clr_idle;
    !(vec_req && vec_ack) |=> (bank0_ack_clear | bank1_ack_clear) == 8'h00;
  endproperty
  a_clr_idle: assert property (p_clr_idle) else $error("clear without ack");
  property p_lvl;
    vec_req |-> vec_level != 2'b00;
  endproperty
  a_lvl: assert property (p_lvl) else $error("disabled level presented");
  property p_src;
    vec_req |-> vec_source < 5'd23;
  endproperty
  a_src: assert property (p_src) else $error("source index out of range");
  property p_pin0;
    1'b1 |=> bank1_source_request[0] == $past(porta_pin_request[0]);
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 not from port A");
  c_top: cover property (vec_req && vec_ack && vec_level == 2'b11);
  c_b1: cover property (bank1_ack_clear != 8'h00);
  c_bus: cover property (ack_o);
endmodule
bind irq_request_priority_enable irq_rpe_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .vec_req(vec_req), .vec_ack(vec_ack),
  .vec_source(vec_source), .vec_level(vec_level), .bank0_ack_clear(bank0_ack_clear),
  .bank1_ack_clear(bank1_ack_clear), .porta_pin_request(porta_pin_request),
  .bank1_source_request(bank1_source_request));
`default_nettype wire

/* File: core_model.sv */
// Processor core side of the vector link, with adjustable acknowledge delay
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Vector link
  input wire logic vec_req,
  input wire logic [3:0] wait_cycles,
  output logic vec_ack
);
  logic [3:0] wait_q;
  // Acks only an offered vector; idle when polled
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !vec_req || vec_ack) begin
      wait_q <= 4'h0;
      vec_ack <= 1'b0;
    end else if (wait_q == wait_cycles) begin
      vec_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: irq_request_priority_enable_tb.sv */
// Self-checking bench for the request and priority block
`timescale 1ns/1ps
`default_nettype none
module irq_request_priority_enable_tb;
  import irq_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, gen_en = 1'b0, wipe = 1'b0;
  logic [13:0] adr_i = 14'h0000;
  logic [3:0] sel_i = 4'hF, core_wait = 4'h0, portd = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [6:0] src7 = 7'h00;
  logic [2:0] alt = 3'h0;
  logic [7:0] b2h = 8'h00, b2l = 8'h00, b0_set = 8'h00, porta = 8'h00, oh;
  logic [7:0] b0_latch = 8'h00, b1_latch = 8'h00, clr0, clr1, b1_src, sv[4];
  logic [31:0] dat_o;
  logic [4:0] vec_source;
  logic [1:0] vec_level;
  logic ack_o, vec_req, vec_ack, irq;
  logic [31:0] rd_q[$];
  logic [6:0] vq[$];
  logic [11:0] regs[5] = '{IDX_BANK0_PRIO_HIGH, IDX_BANK0_PRIO_LOW, IDX_BANK1_PRIO_HIGH,
    IDX_BANK1_PRIO_LOW, IDX_BANK2_REQUEST};
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'h6185;
  always #4 sys_clk = ~sys_clk;
  // Stand-in for the first and second bank latches kept outside the block
  always @(posedge sys_clk) begin
    b0_latch <= (sys_rst || wipe) ? 8'h00 : (b0_latch & ~clr0) | b0_set;
    b1_latch <= (sys_rst || wipe) ? 8'h00 : (b1_latch & ~clr1) | b1_src;
  end
  irq_request_priority_enable dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .multichannel_timer_request(src7[6]), .serial1_receive_request(src7[5]),
    .serial1_transmit_request(src7[4]), .portc_pin_request(src7[3:0]),
    .bank2_enable_high(b2h), .bank2_enable_low(b2l), .bank0_request_latch(b0_latch),
    .bank1_request_latch(b1_latch), .bank0_ack_clear(clr0), .bank1_ack_clear(clr1),
    .porta_pin_request(porta), .portd_pin_request(portd), .low_voltage_detect(alt[2]),
    .comparator0_request(alt[1]), .comparator1_request(alt[0]),
    .bank1_source_request(b1_src), .vec_req(vec_req), .vec_source(vec_source),
    .vec_level(vec_level), .vec_ack(vec_ack), .irq(irq));
  core_model u_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .vec_req(vec_req),
    .wait_cycles(core_wait), .vec_ack(vec_ack));
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= s;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk("bus timeout", 32'h0, 32'h1);
      finish_test();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'hF);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] e);
    rd_q.push_back({24'h000000, e});
    wb(1'b0, idx, 8'h00, 4'hF);
  endtask
  // Highest level first, lowest index on a tie; disabled sources stay pending
  task automatic predict(input logic [22:0] p, input logic [22:0] h, input logic [22:0] l,
                         output logic [22:0] r);
    logic [1:0] best;
    int k;
    r = p;
    repeat (23) begin
      best = 2'b00;
      k = 0;
      for (int i = 22; i >= 0; i--) begin
        if (r[i] && {h[i], l[i]} != 2'b00 && {h[i], l[i]} >= best) begin
          best = {h[i], l[i]};
          k = i;
        end
      end
      if (best != 2'b00) begin
        vq.push_back({k[4:0], best});
        r[k] = 1'b0;
      end
    end
  endtask
  task automatic round();
    logic [22:0] p, h, l, r;
    int n;
    p = 23'($random(seed));
    h = 23'($random(seed));
    l = 23'($random(seed));
    wr(IDX_BANK0_PRIO_HIGH, h[7:0]);
    wr(IDX_BANK0_PRIO_LOW, l[7:0]);
    wr(IDX_BANK1_PRIO_HIGH, h[15:8]);
    wr(IDX_BANK1_PRIO_LOW, l[15:8]);
    b2h <= {1'b0, h[22:16]};
    b2l <= {1'b0, l[22:16]};
    b0_set <= p[7:0];
    porta <= p[15:8];
    core_wait <= 4'($random(seed)) & 4'h3;
    @(posedge sys_clk);
    b0_set <= 8'h00;
    porta <= 8'h00;
    wr(IDX_BANK2_REQUEST, {1'b0, p[22:16]});
    predict(p, h, l, r);
    gen_en <= 1'b1;
    wr(IDX_GLOBAL_CTRL, 8'h01);
    n = 0;
    while (vq.size() != 0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (6) @(posedge sys_clk);
    chk("vectors left", 32'h0, vq.size());
    gen_en <= 1'b0;
    wr(IDX_GLOBAL_CTRL, 8'h00);
    rd(IDX_BANK2_REQUEST, {1'b0, r[22:16]});
    chk("bank0 left", {24'h0, r[7:0]}, {24'h0, b0_latch});
    chk("bank1 left", {24'h0, r[15:8]}, {24'h0, b1_latch});
    wipe <= 1'b1;
    wr(IDX_BANK2_REQUEST, 8'h00);
    wipe <= 1'b0;
  endtask
  // Bus answers and vectors are compared against the oldest note
  always @(posedge sys_clk) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      chk("read data", rd_q.size() ? rd_q.pop_front() : 32'hDEAD_BEEF, dat_o);
    end
    if (vec_req === 1'b1 && vec_ack === 1'b1) begin
      chk("vector", vq.size() ? {25'h0, vq.pop_front()} : 32'hFF, {25'h0, vec_source, vec_level});
    end
    if (vec_req === 1'b1 && gen_en === 1'b0) begin
      chk("polled quiet", 32'h0, 32'h1);
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(regs[i], RESET_VALUE);
    for (int i = 0; i < 4; i++) begin
      sv[i] = 8'($random(seed));
      wr(regs[i], sv[i]);
      rd(regs[i], sv[i]);
    end
    wb(1'b1, IDX_BANK0_PRIO_HIGH, ~sv[0], 4'hE);
    rd(IDX_BANK0_PRIO_HIGH, sv[0]);
    wr(12'h123, 8'hFF);
    rd(12'h123, 8'h00);
    wr(IDX_BANK2_REQUEST, 8'hFF);
    rd(IDX_BANK2_REQUEST, 8'h7F);
    wr(IDX_BANK2_REQUEST, 8'h00);
    b2h <= 8'hFF;
    b2l <= 8'hFF;
    // Polled: each source alone, no vector while globally off
    for (int i = 0; i < 7; i++) begin
      src7 <= 7'h01 << i;
      @(posedge sys_clk);
      src7 <= 7'h00;
      rd(IDX_BANK2_REQUEST, 8'h01 << i);
      wr(IDX_BANK2_REQUEST, 8'h00);
    end
    rd(IDX_EVENT_STATUS, 8'h01);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(IDX_EVENT_MASK, 8'h01);
    @(posedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IDX_EVENT_STATUS, 8'h01);
    @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(IDX_EVENT_MASK, 8'h02);
    repeat (6) round();
    @(posedge sys_clk);
    chk("irq on ack", 32'h1, {31'h0, irq});
    wr(IDX_EVENT_STATUS, 8'h02);
    wr(IDX_SHARED_SELECT, 8'hFF);
    rd(IDX_SHARED_SELECT, 8'hFE);
    // Alternate sources steered; pin 0 always follows port A
    for (int j = 1; j < 8; j++) begin
      oh = 8'h01 << j;
      alt <= oh[7:5];
      portd <= oh[4:1];
      porta <= ~oh;
      @(posedge sys_clk);
      alt <= 3'h0;
      portd <= 4'h0;
      porta <= 8'h00;
      repeat (3) @(posedge sys_clk);
      chk("bank1 steer", {24'h0, oh | 8'h01}, {24'h0, b1_latch});
      wipe <= 1'b1;
      @(posedge sys_clk);
      wipe <= 1'b0;
    end
    finish_test();
  end
endmodule
`default_nettype wire
